// ===== src/sfp_regs.svh
// Opcodes, bit counts, table addresses and table byte values for the parameter store
`ifndef SFP_REGS_SVH
`define SFP_REGS_SVH

// ****************************************************************
// Link command and phase lengths
// ****************************************************************
`define SFP_OP_READ      8'h5a
`define SFP_CMD_LAST     5'h07
`define SFP_ADDR_LAST    5'h17
`define SFP_DUMMY_LAST   5'h07
`define SFP_BIT_ZERO     5'h00
`define SFP_BIT_ONE      5'h01
`define SFP_BYTE_MASK    5'h07
`define SFP_BYTE_START   3'h0
`define SFP_ADDR_STEP    24'h000001
`define SFP_ADDR_RESET   24'h000000
`define SFP_RX_RESET     24'h000000
`define SFP_TX_RESET     8'hff
`define SFP_FILL         8'hff

// ****************************************************************
// Table addresses
// ****************************************************************
`define SFP_A_BASE       24'h000030
`define SFP_A_ERASE4K    24'h000031
`define SFP_A_FEAT       24'h000032
`define SFP_A_PAD33      24'h000033
`define SFP_A_DENS0      24'h000034
`define SFP_A_DENS1      24'h000035
`define SFP_A_DENS2      24'h000036
`define SFP_A_DENS3      24'h000037
`define SFP_A_Q144_WM    24'h000038
`define SFP_A_Q144_OP    24'h000039
`define SFP_A_Q114_WM    24'h00003a
`define SFP_A_Q114_OP    24'h00003b
`define SFP_A_D112_WM    24'h00003c
`define SFP_A_D112_OP    24'h00003d
`define SFP_A_D122_WM    24'h00003e
`define SFP_A_D122_OP    24'h00003f
`define SFP_A_FEAT2      24'h000040
`define SFP_A_D222_WM    24'h000046
`define SFP_A_D222_OP    24'h000047
`define SFP_A_Q444_WM    24'h00004a
`define SFP_A_Q444_OP    24'h00004b
`define SFP_A_ST1_SIZE   24'h00004c
`define SFP_A_ST1_OP     24'h00004d
`define SFP_A_ST2_SIZE   24'h00004e
`define SFP_A_ST2_OP     24'h00004f
`define SFP_A_ST3_SIZE   24'h000050
`define SFP_A_ST3_OP     24'h000051
`define SFP_A_ST4_SIZE   24'h000052
`define SFP_A_ST4_OP     24'h000053

// ****************************************************************
// First byte fields
// ****************************************************************
`define SFP_ERASE_4K     2'h1
`define SFP_WR_GRAN      1'h1
`define SFP_VOL_STAT     1'h0
`define SFP_VWE_OPSEL    1'h0
`define SFP_B30_UNUSED   3'h7

// ****************************************************************
// Feature byte fields
// ****************************************************************
`define SFP_SUP_112      1'h1
`define SFP_ADDR_3B      2'h0
`define SFP_SUP_DTR      1'h0
`define SFP_SUP_122      1'h1
`define SFP_SUP_144      1'h1
`define SFP_SUP_114      1'h1
`define SFP_FEAT_UNUSED  1'h1
`define SFP_SUP_222      1'h0
`define SFP_SUP_444      1'h0
`define SFP_F2_UNUSED    3'h7

// ****************************************************************
// Fast read wait and mode fields, opcodes
// ****************************************************************
`define SFP_Q144_WAIT    5'h04
`define SFP_Q144_MODE    3'h2
`define SFP_Q144_OP      8'heb
`define SFP_Q114_WAIT    5'h08
`define SFP_Q114_MODE    3'h0
`define SFP_Q114_OP      8'h6b
`define SFP_D112_WAIT    5'h08
`define SFP_D112_MODE    3'h0
`define SFP_D112_OP      8'h3b
`define SFP_D122_WAIT    5'h02
`define SFP_D122_MODE    3'h2
`define SFP_D122_OP      8'hbb
`define SFP_NONE_WAIT    5'h00
`define SFP_NONE_MODE    3'h0
`define SFP_NONE_OP      8'hff

// ****************************************************************
// Sector types: size exponent and erase opcode
// ****************************************************************
`define SFP_ST1_SIZE     8'h0c
`define SFP_ST1_OP       8'h20
`define SFP_ST2_SIZE     8'h0f
`define SFP_ST2_OP       8'h52
`define SFP_ST3_SIZE     8'h10
`define SFP_ST3_OP       8'hd8
`define SFP_ST4_SIZE     8'h00
`define SFP_ST4_OP       8'hff

`endif

// ===== src/sfp_pkg.sv
// Types shared by the parameter store modules
package sfp_pkg;

  // ****************************************************************
  // Link phases
  // ****************************************************************
  typedef enum logic [2:0] {
    SFP_ST_CMD,
    SFP_ST_ADDR,
    SFP_ST_DUMMY,
    SFP_ST_DATA,
    SFP_ST_IGNORE
  } sfp_state_e;

  typedef logic [7:0]  sfp_byte_t;
  typedef logic [23:0] sfp_addr_t;

endpackage

// ===== src/sfp_rom.sv
// Fixed lookup of the basic flash parameter table bytes
`include "sfp_regs.svh"

module sfp_rom
  import sfp_pkg::*;
#(
  parameter logic [31:0] DENSITY = 32'hffff_ffff
)
(
  input  wire sfp_addr_t ADDR,
  output sfp_byte_t      DATA
);

  // ****************************************************************
  // Table contents, constant by construction
  // ****************************************************************

  // Byte select; everything off the table reads as fill
  always_comb
  begin
    unique case (ADDR)
      // RL2 RL3 RL4 RL5 RL6: first table byte
      `SFP_A_BASE:     DATA = {`SFP_B30_UNUSED, `SFP_VWE_OPSEL, `SFP_VOL_STAT,
                               `SFP_WR_GRAN, `SFP_ERASE_4K};
      `SFP_A_ERASE4K:  DATA = `SFP_ST1_OP;
      // RL7 RL8: address width, mode support
      `SFP_A_FEAT:     DATA = {`SFP_FEAT_UNUSED, `SFP_SUP_114, `SFP_SUP_144, `SFP_SUP_122,
                               `SFP_SUP_DTR, `SFP_ADDR_3B, `SFP_SUP_112};
      `SFP_A_DENS0:    DATA = DENSITY[7:0];
      `SFP_A_DENS1:    DATA = DENSITY[15:8];
      `SFP_A_DENS2:    DATA = DENSITY[23:16];
      `SFP_A_DENS3:    DATA = DENSITY[31:24];
      // RL9 RL10 RL11 RL12: fast read entries
      `SFP_A_Q144_WM:  DATA = {`SFP_Q144_MODE, `SFP_Q144_WAIT};
      `SFP_A_Q144_OP:  DATA = `SFP_Q144_OP;
      `SFP_A_Q114_WM:  DATA = {`SFP_Q114_MODE, `SFP_Q114_WAIT};
      `SFP_A_Q114_OP:  DATA = `SFP_Q114_OP;
      `SFP_A_D112_WM:  DATA = {`SFP_D112_MODE, `SFP_D112_WAIT};
      `SFP_A_D112_OP:  DATA = `SFP_D112_OP;
      `SFP_A_D122_WM:  DATA = {`SFP_D122_MODE, `SFP_D122_WAIT};
      `SFP_A_D122_OP:  DATA = `SFP_D122_OP;
      // RL13 RL14: unsupported wide modes
      `SFP_A_FEAT2:    DATA = {`SFP_F2_UNUSED, `SFP_SUP_444, `SFP_F2_UNUSED, `SFP_SUP_222};
      `SFP_A_D222_WM:  DATA = {`SFP_NONE_MODE, `SFP_NONE_WAIT};
      `SFP_A_D222_OP:  DATA = `SFP_NONE_OP;
      `SFP_A_Q444_WM:  DATA = {`SFP_NONE_MODE, `SFP_NONE_WAIT};
      `SFP_A_Q444_OP:  DATA = `SFP_NONE_OP;
      // RL15 RL16 RL17 RL18 RL19: sector types
      `SFP_A_ST1_SIZE: DATA = `SFP_ST1_SIZE;
      `SFP_A_ST1_OP:   DATA = `SFP_ST1_OP;
      `SFP_A_ST2_SIZE: DATA = `SFP_ST2_SIZE;
      `SFP_A_ST2_OP:   DATA = `SFP_ST2_OP;
      `SFP_A_ST3_SIZE: DATA = `SFP_ST3_SIZE;
      `SFP_A_ST3_OP:   DATA = `SFP_ST3_OP;
      `SFP_A_ST4_SIZE: DATA = `SFP_ST4_SIZE;
      `SFP_A_ST4_OP:   DATA = `SFP_ST4_OP;
      default:         DATA = `SFP_FILL;
    endcase
  end

endmodule

// ===== src/sfp_param_rom.sv
// Serial link slave that answers the parameter read command from the fixed table
`include "sfp_regs.svh"

// Function
// RL1: Read command 5AH returns bytes at address
// RL2: Table starts at byte address 30H
// RL3: First byte bits 1:0 read 01b
// RL4: First byte bit 2 reads one
// RL5: First byte bits 4:3 read 00b
// RL6: Bits 7:5 fixed, byte 30H reads E5H
// RL7: Address width field reads 00b
// RL8: Byte 32H reads F1H, no DTR
// RL9: Quad-I/O read: EBH, byte 38H 44H
// RL10: Quad-output read: 6BH, eight dummies, no mode
// RL11: Dual-output read: 3BH at 3DH
// RL12: Dual-I/O read: BBH, byte 3EH 42H
// RL13: Dual-dual-dual unsupported, byte 40H EEH
// RL14: Quad-quad-quad unsupported, 4BH reads FFH
// RL15: Sector size is power-of-two exponent
// RL16: Sector type 1: 4 KB, 20H
// RL17: Sector type 2: 32 KB, 52H
// RL18: Sector type 3: exponent 10H, D8H
// RL19: Sector type 4 absent: 00H, FFH
// RL20: Host reads zero wait as unsupported
// RL21: Host reads zero mode count as none
// RL22: Table bytes never change
module sfp_param_rom
  import sfp_pkg::*;
#(
  parameter logic [31:0] DENSITY = 32'hffff_ffff
)
(
  input  wire logic CLK,
  input  wire logic RST_N,
  input  wire logic CS_N,
  input  wire logic SCLK,
  input  wire logic SI,
  output logic      SO,
  output logic      SO_OE
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic       cs_m;
  logic       cs_s;
  logic       sclk_m;
  logic       sclk_s;
  logic       sclk_d;
  logic       si_m;
  logic       si_s;
  logic       rise;
  logic       fall;

  // Two stages per pin, one more on the clock for edges
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      cs_m   <= 1'b1;
      cs_s   <= 1'b1;
      sclk_m <= 1'b0;
      sclk_s <= 1'b0;
      sclk_d <= 1'b0;
      si_m   <= 1'b0;
      si_s   <= 1'b0;
    end
    else
    begin
      cs_m   <= CS_N;
      cs_s   <= cs_m;
      sclk_m <= SCLK;
      sclk_s <= sclk_m;
      sclk_d <= sclk_s;
      si_m   <= SI;
      si_s   <= si_m;
    end
  end

  // Edge pulses of the link clock
  assign rise = sclk_s & ~sclk_d;
  assign fall = ~sclk_s & sclk_d;

  // ****************************************************************
  // Command, address, dummy and data phases
  // ****************************************************************
  sfp_state_e state;
  sfp_state_e next_state;
  logic [4:0] bit_cnt;
  logic [4:0] next_bit_cnt;
  sfp_addr_t  rx;
  sfp_addr_t  next_rx;
  sfp_addr_t  rx_in;
  sfp_addr_t  addr;
  sfp_addr_t  next_addr;
  sfp_byte_t  tx;
  sfp_byte_t  next_tx;
  logic       so_oe;
  logic       next_so_oe;
  logic       ld_byte;
  sfp_byte_t  rom_byte;

  // Table lookup; no write path reaches it
  sfp_rom #(
    .DENSITY (DENSITY)
  ) u_rom (
    .ADDR (addr),
    .DATA (rom_byte)
  );

  assign rx_in   = {rx[22:0], si_s};
  assign ld_byte = fall & ~cs_s & (state == SFP_ST_DATA)
                 & (bit_cnt[2:0] == `SFP_BYTE_START);

  // Next phase, shift and output values
  always_comb
  begin
    next_state   = state;
    next_bit_cnt = bit_cnt;
    next_rx      = rx;
    next_addr    = addr;
    next_tx      = tx;
    next_so_oe   = so_oe;
    if (cs_s)
    begin
      next_state   = SFP_ST_CMD;
      next_bit_cnt = `SFP_BIT_ZERO;
      next_so_oe   = 1'b0;
    end
    else if (rise)
    begin
      unique case (state)
        SFP_ST_CMD:
        begin
          next_rx      = rx_in;
          next_bit_cnt = bit_cnt + `SFP_BIT_ONE;
          if (bit_cnt == `SFP_CMD_LAST)
          begin
            next_bit_cnt = `SFP_BIT_ZERO;
            // RL1: opcode decode
            next_state   = (rx_in[7:0] == `SFP_OP_READ) ? SFP_ST_ADDR : SFP_ST_IGNORE;
          end
        end
        SFP_ST_ADDR:
        begin
          next_rx      = rx_in;
          next_bit_cnt = bit_cnt + `SFP_BIT_ONE;
          if (bit_cnt == `SFP_ADDR_LAST)
          begin
            next_bit_cnt = `SFP_BIT_ZERO;
            next_addr    = rx_in;
            next_state   = SFP_ST_DUMMY;
          end
        end
        SFP_ST_DUMMY:
        begin
          next_bit_cnt = bit_cnt + `SFP_BIT_ONE;
          if (bit_cnt == `SFP_DUMMY_LAST)
          begin
            next_bit_cnt = `SFP_BIT_ZERO;
            next_state   = SFP_ST_DATA;
            next_so_oe   = 1'b1;
          end
        end
        SFP_ST_DATA,
        SFP_ST_IGNORE:
        begin
          next_state = state;
        end
      endcase
    end
    else if (fall && state == SFP_ST_DATA)
    begin
      // RL22: table byte loaded as stored
      if (ld_byte)
      begin
        next_tx   = rom_byte;
        next_addr = addr + `SFP_ADDR_STEP;
      end
      else
      begin
        next_tx = {tx[6:0], 1'b0};
      end
      next_bit_cnt = (bit_cnt + `SFP_BIT_ONE) & `SFP_BYTE_MASK;
    end
  end

  // Phase registers
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state   <= SFP_ST_CMD;
      bit_cnt <= `SFP_BIT_ZERO;
      rx      <= `SFP_RX_RESET;
      addr    <= `SFP_ADDR_RESET;
      tx      <= `SFP_TX_RESET;
      so_oe   <= 1'b0;
    end
    else
    begin
      state   <= next_state;
      bit_cnt <= next_bit_cnt;
      rx      <= next_rx;
      addr    <= next_addr;
      tx      <= next_tx;
      so_oe   <= next_so_oe;
    end
  end

  assign SO    = tx[7];   // Most significant bit first
  assign SO_OE = so_oe;   // Driven only in the data phase

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  property p_rl1;
    (!cs_s && rise && state == SFP_ST_CMD && bit_cnt == `SFP_CMD_LAST
     && rx_in[7:0] == 8'h5a) |=> (state == SFP_ST_ADDR) ##0 !SO_OE;
  endproperty
  a_rl1: assert property (p_rl1) else $error("read opcode not accepted"); // RL1

  property p_rl2;
    (ld_byte && addr == 24'h000030) |=> (tx == 8'he5) ##1 (addr == 24'h000031);
  endproperty
  a_rl2: assert property (p_rl2) else $error("table start byte wrong"); // RL2

  property p_rl3;
    (ld_byte && addr == `SFP_A_BASE) |=> tx[1:0] == 2'b01;
  endproperty
  a_rl3: assert property (p_rl3) else $error("erase size field wrong"); // RL3

  property p_rl4;
    (ld_byte && addr == `SFP_A_BASE) |=> tx[2];
  endproperty
  a_rl4: assert property (p_rl4) else $error("write granularity wrong"); // RL4

  property p_rl5;
    (ld_byte && addr == `SFP_A_BASE) |=> tx[4:3] == 2'b00;
  endproperty
  a_rl5: assert property (p_rl5) else $error("status write bits wrong"); // RL5

  property p_rl6;
    (ld_byte && addr == `SFP_A_BASE) |=> (tx[7:5] == 3'b111) && SO;
  endproperty
  a_rl6: assert property (p_rl6) else $error("fixed bits wrong"); // RL6

  property p_rl7;
    (ld_byte && addr == `SFP_A_FEAT) |=> tx[2:1] == 2'b00;
  endproperty
  a_rl7: assert property (p_rl7) else $error("address width wrong"); // RL7

  property p_rl8;
    (ld_byte && addr == `SFP_A_FEAT) |=> (tx == 8'hf1) && !tx[3];
  endproperty
  a_rl8: assert property (p_rl8) else $error("feature byte wrong"); // RL8

  property p_rl9;
    ((ld_byte && addr == `SFP_A_Q144_WM) |=> tx == 8'h44)
    and ((ld_byte && addr == `SFP_A_Q144_OP) |=> tx == 8'heb);
  endproperty
  a_rl9: assert property (p_rl9) else $error("quad io read entry wrong"); // RL9

  property p_rl10;
    ((ld_byte && addr == `SFP_A_Q114_WM) |=> tx == 8'h08)
    and ((ld_byte && addr == `SFP_A_Q114_OP) |=> tx == 8'h6b);
  endproperty
  a_rl10: assert property (p_rl10) else $error("quad out read entry wrong"); // RL10

  property p_rl11;
    ((ld_byte && addr == `SFP_A_D112_WM) |=> tx == 8'h08)
    and ((ld_byte && addr == `SFP_A_D112_OP) |=> tx == 8'h3b);
  endproperty
  a_rl11: assert property (p_rl11) else $error("dual out read entry wrong"); // RL11

  property p_rl12;
    ((ld_byte && addr == `SFP_A_D122_WM) |=> tx == 8'h42)
    and ((ld_byte && addr == `SFP_A_D122_OP) |=> tx == 8'hbb);
  endproperty
  a_rl12: assert property (p_rl12) else $error("dual io read entry wrong"); // RL12

  property p_rl13;
    ((ld_byte && addr == `SFP_A_FEAT2) |=> tx == 8'hee)
    and ((ld_byte && addr == `SFP_A_D222_WM) |=> tx == 8'h00)
    and ((ld_byte && addr == `SFP_A_D222_OP) |=> tx == 8'hff);
  endproperty
  a_rl13: assert property (p_rl13) else $error("dual dual dual entry wrong"); // RL13

  property p_rl14;
    ((ld_byte && addr == `SFP_A_Q444_WM) |=> tx == 8'h00)
    and ((ld_byte && addr == `SFP_A_Q444_OP) |=> tx == 8'hff);
  endproperty
  a_rl14: assert property (p_rl14) else $error("quad quad quad entry wrong"); // RL14

  property p_rl15;
    (ld_byte && addr == `SFP_A_ST1_SIZE) |=> tx == 8'h0c;
  endproperty
  a_rl15: assert property (p_rl15) else $error("size exponent wrong"); // RL15

  property p_rl16;
    (ld_byte && addr == `SFP_A_ST1_OP) |=> tx == 8'h20;
  endproperty
  a_rl16: assert property (p_rl16) else $error("sector type 1 opcode wrong"); // RL16

  property p_rl17;
    ((ld_byte && addr == `SFP_A_ST2_SIZE) |=> tx == 8'h0f)
    and ((ld_byte && addr == `SFP_A_ST2_OP) |=> tx == 8'h52);
  endproperty
  a_rl17: assert property (p_rl17) else $error("sector type 2 wrong"); // RL17

  property p_rl18;
    ((ld_byte && addr == `SFP_A_ST3_SIZE) |=> tx == 8'h10)
    and ((ld_byte && addr == `SFP_A_ST3_OP) |=> tx == 8'hd8);
  endproperty
  a_rl18: assert property (p_rl18) else $error("sector type 3 wrong"); // RL18

  property p_rl19;
    ((ld_byte && addr == `SFP_A_ST4_SIZE) |=> tx == 8'h00)
    and ((ld_byte && addr == `SFP_A_ST4_OP) |=> tx == 8'hff);
  endproperty
  a_rl19: assert property (p_rl19) else $error("sector type 4 wrong"); // RL19

  property p_rl22;
    $stable(addr) |-> $stable(rom_byte) && (addr != `SFP_A_BASE || rom_byte == 8'he5);
  endproperty
  a_rl22: assert property (p_rl22) else $error("table byte changed"); // RL22

  c_read:   cover property (state == SFP_ST_ADDR ##[1:1000] state == SFP_ST_DATA);
  c_base:   cover property (ld_byte && addr == `SFP_A_BASE);
  c_ignore: cover property (state == SFP_ST_IGNORE);
  c_abort:  cover property (state == SFP_ST_DATA ##1 cs_s);

endmodule

// ===== sim/sfp_host_model.sv
// Behavioural host controller that reads the parameter store over the serial link
module sfp_host_model (
  input  wire logic        START,
  input  wire logic [7:0]  OPCODE,
  input  wire logic [23:0] ADDR,
  input  wire logic [7:0]  NBYTES,
  input  wire logic        SO,
  input  wire logic        SO_OE,
  output logic             CS_N,
  output logic             SCLK,
  output logic             SI,
  output logic             BUSY,
  output logic             BYTE_VALID,
  output logic [7:0]       BYTE_DATA,
  output logic             SEEN_OE,
  output logic             LATE_OE
);
  timeunit 1ns;
  timeprecision 1ps;

  int   i;
  int   j;
  logic r;
  logic [7:0] data;

  // One link cycle, mode 0, sample on rise
  task automatic clock_bit(input logic b);
    SI = b;
    #100;
    SCLK = 1'b1;
    r = SO;
    BYTE_VALID = 1'b0;
    #100;
    SCLK = 1'b0;
  endtask

  // Idle data line keeps changing so no stale value looks valid
  always #100
  begin
    if (CS_N)
      SI = ~SI;
  end

  // ****************************************************************
  // Frame sequencer
  // ****************************************************************
  initial
  begin
    CS_N = 1'b1;
    SCLK = 1'b0;
    SI = 1'b0;
    BUSY = 1'b0;
    BYTE_VALID = 1'b0;
    BYTE_DATA = 8'h00;
    SEEN_OE = 1'b0;
    LATE_OE = 1'b0;
    forever
    begin
      @(posedge START);
      BUSY = 1'b1;
      SEEN_OE = 1'b0;
      #37;
      CS_N = 1'b0;
      #100;
      for (i = 0; i < 40; i++)
        clock_bit(i < 8 ? OPCODE[7 - i] : (i < 32 ? ADDR[31 - i] : ~SI));
      for (j = 0; j < int'(NBYTES); j++)
      begin
        for (i = 0; i < 8; i++)
        begin
          clock_bit(~SI);
          data = {data[6:0], r};
          if (SO_OE === 1'b1)
            SEEN_OE = 1'b1;
        end
        BYTE_DATA = data;
        BYTE_VALID = 1'b1;
      end
      #100;
      BYTE_VALID = 1'b0;
      CS_N = 1'b1;
      #200;
      LATE_OE = SO_OE;
      BUSY = 1'b0;
    end
  end
endmodule

// ===== sim/sfp_param_rom_tb_top.sv
// Self-checking bench for the parameter store read path
module sfp_param_rom_tb_top
  import sfp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] DENS = 32'h1234_5678;

  logic       CLK;
  logic       RST_N;
  logic       start;
  logic [7:0] opcode;
  sfp_addr_t  addr;
  logic [7:0] nbytes;
  logic       cs_n, sclk, si, so, so_oe;
  logic       busy, byte_valid, seen_oe, late_oe, ign;
  sfp_byte_t  byte_data;
  sfp_byte_t  exp_q[$];
  int         n_fail, checked, seed, n;
  sfp_addr_t  a;
  logic [7:0] bad_ops[4] = '{8'h03, 8'h02, 8'h20, 8'h9f};

  sfp_param_rom #(.DENSITY(DENS)) sfp_param_rom_i (
    .CLK(CLK), .RST_N(RST_N), .CS_N(cs_n), .SCLK(sclk), .SI(si), .SO(so), .SO_OE(so_oe));

  sfp_host_model sfp_host_model_i (
    .START(start), .OPCODE(opcode), .ADDR(addr), .NBYTES(nbytes), .SO(so), .SO_OE(so_oe),
    .CS_N(cs_n), .SCLK(sclk), .SI(si), .BUSY(busy), .BYTE_VALID(byte_valid),
    .BYTE_DATA(byte_data), .SEEN_OE(seen_oe), .LATE_OE(late_oe));

  initial
  begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  // Expected table byte, built from its fields
  function automatic sfp_byte_t exp_byte(input sfp_addr_t x);
    exp_byte = 8'hff;
    case (x)
      24'h000030: exp_byte = {3'h7, 1'h0, 1'h0, 1'h1, 2'h1};
      24'h000031: exp_byte = 8'h20;
      24'h000032: exp_byte = {1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 2'h0, 1'h1};
      24'h000034: exp_byte = DENS[7:0];
      24'h000035: exp_byte = DENS[15:8];
      24'h000036: exp_byte = DENS[23:16];
      24'h000037: exp_byte = DENS[31:24];
      24'h000038: exp_byte = {3'h2, 5'h04};
      24'h000039: exp_byte = 8'heb;
      24'h00003a: exp_byte = {3'h0, 5'h08};
      24'h00003b: exp_byte = 8'h6b;
      24'h00003c: exp_byte = {3'h0, 5'h08};
      24'h00003d: exp_byte = 8'h3b;
      24'h00003e: exp_byte = {3'h2, 5'h02};
      24'h00003f: exp_byte = 8'hbb;
      24'h000040: exp_byte = {3'h7, 1'h0, 3'h7, 1'h0};
      24'h000046: exp_byte = {3'h0, 5'h00};
      24'h00004a: exp_byte = {3'h0, 5'h00};
      24'h00004c: exp_byte = 8'h0c;
      24'h00004d: exp_byte = 8'h20;
      24'h00004e: exp_byte = 8'h0f;
      24'h00004f: exp_byte = 8'h52;
      24'h000050: exp_byte = 8'h10;
      24'h000051: exp_byte = 8'hd8;
      24'h000052: exp_byte = 8'h00;
      default: exp_byte = 8'hff;
    endcase
  endfunction

  task automatic check(input sfp_byte_t seen, input sfp_byte_t want);
    checked++;
    if (seen !== want)
    begin
      n_fail++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // One frame; quiet frames expect no data
  task automatic frame(input logic [7:0] op, input sfp_addr_t x, input int cnt, input logic quiet);
    int k;
    ign = quiet;
    if (!quiet)
      for (k = 0; k < cnt; k++)
        exp_q.push_back(exp_byte(x + sfp_addr_t'(k)));
    opcode <= op;
    addr <= x;
    nbytes <= cnt[7:0];
    start <= 1'b1;
    @(posedge CLK);
    start <= 1'b0;
    for (k = 0; k < 20000 && (k < 2 || busy !== 1'b0); k++)
      @(posedge CLK);
    if (busy !== 1'b0)
    begin
      n_fail++;
      stop_test();
    end
  endtask

  task automatic good_end();
    check({7'h0, seen_oe}, 8'h01);
    check({7'h0, late_oe}, 8'h00);
    check(exp_q.size() == 0 ? 8'h00 : 8'h01, 8'h00);
  endtask

  // ****************************************************************
  // Result watcher
  // ****************************************************************
  always @(posedge byte_valid)
  begin
    if (!ign)
    begin
      if (exp_q.size() == 0)
        check(8'h01, 8'h00);
      else
        check(byte_data, exp_q.pop_front());
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    seed = 77;
    n_fail = 0;
    checked = 0;
    ign = 1'b0;
    start = 1'b0;
    opcode = 8'h00;
    addr = 24'h000000;
    nbytes = 8'h00;
    RST_N = 1'b0;
    repeat (3) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (4) @(posedge CLK);
    // sweep from header edge past table end
    frame(8'h5a, 24'h00002e, 40, 1'b0);
    good_end();
    $display("sweep done");
    repeat (6)
    begin
      a = 24'h000028 + sfp_addr_t'($unsigned($random(seed)) % 48);
      n = 1 + int'($unsigned($random(seed)) % 4);
      frame(8'h5a, a, n, 1'b0);
      good_end();
    end
    $display("random reads done");
    foreach (bad_ops[i])
    begin
      frame(bad_ops[i], 24'h000030, 2, 1'b1);
      check({7'h0, seen_oe}, 8'h00);
    end
    frame(8'h5a, 24'h000030, 4, 1'b0);
    good_end();
    $display("refused opcodes done");
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    check({6'h0, so, so_oe}, 8'h02);
    RST_N <= 1'b1;
    repeat (4) @(posedge CLK);
    frame(8'h5a, 24'hfffffe, 4, 1'b0);
    good_end();
    frame(8'h5a, 24'h000046, 14, 1'b0);
    good_end();
    $display("reset and wrap done");
    stop_test();
  end
endmodule
